// ### design/gpr_regs.sv
// Gigabit control/status register bank with indirect extended register window.
// Assumes inputs synchronous to CLK and a master that never issues RD and WR together.
`timescale 1ns/1ns

//
// Behaviour
// - Three-bit test mode picks normal, waveform, jitter master, jitter slave, distortion.
// - Test mode only reaches the transmitter in gigabit twisted-pair mode.
// - Forced role enable overrides automatic role resolution; enable resets to zero.
// - Forced role value: zero slave, one master, honoured only while enabled.
// - Port type bit advertises multi-port when set; resets to one.
// - Bits nine and eight advertise gigabit full and half duplex; reset one.
// - Role fault sets on detected fault, clears when status register is read.
// - Role resolved bit reports negotiated role, one for master; resets one.
// - Bit thirteen reports local receiver OK.
// - Bit twelve reports remote receiver OK.
// - Bits eleven and ten report partner gigabit full and half duplex.
// - Function field: address, data, data with increment, data with write increment.
// - Function two steps address after reads and writes; three after writes only.
// - Five-bit device select picks the extended device targeted.
// - Function zero writes set target address; otherwise access transfers data.
// - Extended registers reachable only through the indirect pair.
// - Capability register reads no fibre, copper gigabit full and half duplex.
// - Transmitted next-page toggle alternates for each page sent.
module gpr_regs
  import gpr_pkg::*;
#(
  parameter int MMD_ADDR_BITS = 4
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // Register access port
  input wire logic [4:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  // Status from the gigabit core
  input wire logic SPEED_GIG,
  input wire logic ROLE_FAULT_EVT,
  input wire logic ROLE_IS_MASTER,
  input wire logic LOCAL_RX_OK,
  input wire logic REMOTE_RX_OK,
  input wire logic PARTNER_GIG_FDX,
  input wire logic PARTNER_GIG_HDX,
  input wire logic IDLE_ERR_EVT,
  input wire logic PAGE_SENT,
  // Configuration to the gigabit core
  output logic [2:0] TEST_MODE,
  output logic FORCE_ROLE_ENABLE,
  output logic FORCE_ROLE_MASTER,
  output logic ADVERTISE_MULTI_PORT,
  output logic ADVERTISE_GIG_FDX,
  output logic ADVERTISE_GIG_HDX,
  output logic NEXT_PAGE_TOGGLE
);

  localparam int IDX_W = MMD_ADDR_BITS + 1;
  localparam int EXT_DEPTH = 2 ** IDX_W;

  if (MMD_ADDR_BITS < 1 || MMD_ADDR_BITS > 8)
  begin : g_bad_depth
    $error("MMD_ADDR_BITS must lie between 1 and 8");
  end

  // Storage slot of an extended register: device picks the half, address the word
  function automatic logic [IDX_W-1:0] ext_index(input logic [4:0] dev,
                                                  input logic [15:0] addr);
    ext_index = {dev == DEV_AN, addr[MMD_ADDR_BITS-1:0]};
  endfunction : ext_index

  // Control fields
  logic [2:0] test_mode;
  logic forced_role_enable;
  logic forced_role_value;
  logic port_type;
  logic advertise_gig_full_duplex;
  logic advertise_gig_half_duplex;

  // Status fields
  logic role_fault;
  logic role_resolved;
  logic local_ok;
  logic remote_ok;
  logic partner_gig_full_duplex;
  logic partner_gig_half_duplex;
  logic [7:0] idle_error_counter;

  // Indirect access state
  gpr_func_t indirect_function;
  logic [4:0] indirect_device_select;
  logic [15:0] held_addr;
  logic [15:0] ext_mem [0:EXT_DEPTH-1];

  // Address decode
  wire sel_np = ADDR == OFS_NP_TX;
  wire sel_ctrl = ADDR == OFS_CTRL;
  wire sel_stat = ADDR == OFS_STAT;
  wire sel_acc = ADDR == OFS_ACC;
  wire sel_ad = ADDR == OFS_ADDR_DATA;
  wire sel_cap = ADDR == OFS_CAP;
  wire wr_ctrl = WR && sel_ctrl;
  wire wr_acc = WR && sel_acc;
  wire wr_ad = WR && sel_ad;
  wire rd_ad = RD && sel_ad;
  wire rd_stat = RD && sel_stat;

  // Indirect function decode
  wire is_data_fn = indirect_function != GPR_FN_ADDR;
  wire inc_on_wr = indirect_function == GPR_FN_DATA_INC_RW
                   || indirect_function == GPR_FN_DATA_INC_W;
  wire inc_on_rd = indirect_function == GPR_FN_DATA_INC_RW;
  wire data_wr = wr_ad && is_data_fn;
  wire data_rd = rd_ad && is_data_fn;
  wire step_addr = (data_wr && inc_on_wr) || (data_rd && inc_on_rd);
  wire [15:0] next_held_addr = (wr_ad && !is_data_fn) ? WDATA
                               : step_addr ? 16'(held_addr + 16'h0001)
                               : held_addr;

  // Only two devices have storage, and only the low window of each
  wire dev_backed = indirect_device_select == DEV_PCS
                    || indirect_device_select == DEV_AN;
  wire addr_in_window = (held_addr >> MMD_ADDR_BITS) == 16'h0000;
  wire ext_hit = dev_backed && addr_in_window;
  wire [IDX_W-1:0] ext_slot = ext_index(indirect_device_select, held_addr);
  wire [15:0] ext_rd = ext_hit ? ext_mem[ext_slot] : 16'h0000;

  // Saturating counter and clear-on-read; an event on the read cycle survives
  wire cnt_bump = IDLE_ERR_EVT && idle_error_counter != CNT_MAX;
  wire [7:0] next_idle_error_counter = rd_stat ? {7'h00, IDLE_ERR_EVT}
                                       : cnt_bump ? 8'(idle_error_counter + 8'h01)
                                       : idle_error_counter;
  wire next_role_fault = ROLE_FAULT_EVT || (role_fault && !rd_stat);

  // Read words; unused bits read zero
  wire [15:0] ctrl_word;
  assign ctrl_word[CTRL_TEST_HI:CTRL_TEST_LO] = test_mode;
  assign ctrl_word[CTRL_FORCE_EN_BIT] = forced_role_enable;
  assign ctrl_word[CTRL_FORCE_VAL_BIT] = forced_role_value;
  assign ctrl_word[CTRL_PORT_TYPE_BIT] = port_type;
  assign ctrl_word[CTRL_ADV_FDX_BIT] = advertise_gig_full_duplex;
  assign ctrl_word[CTRL_ADV_HDX_BIT] = advertise_gig_half_duplex;
  assign ctrl_word[CTRL_RSVD_HI:0] = 8'h00;

  wire [15:0] stat_word;
  assign stat_word[STAT_FAULT_BIT] = role_fault;
  assign stat_word[STAT_RESOLVED_BIT] = role_resolved;
  assign stat_word[STAT_LOCAL_OK_BIT] = local_ok;
  assign stat_word[STAT_REMOTE_OK_BIT] = remote_ok;
  assign stat_word[STAT_LP_FDX_BIT] = partner_gig_full_duplex;
  assign stat_word[STAT_LP_HDX_BIT] = partner_gig_half_duplex;
  assign stat_word[STAT_RSVD_HI:STAT_RSVD_LO] = 2'b00;
  assign stat_word[STAT_CNT_HI:0] = idle_error_counter;

  wire [15:0] acc_word;
  assign acc_word[ACC_FUNC_HI:ACC_FUNC_LO] = indirect_function;
  assign acc_word[ACC_RSVD_HI:ACC_RSVD_LO] = 9'h000;
  assign acc_word[ACC_DEV_HI:0] = indirect_device_select;

  wire [15:0] np_word = 16'(NEXT_PAGE_TOGGLE) << NP_TOGGLE_BIT;

  // Extended registers appear nowhere in the main map; unmapped reads give zero
  wire [15:0] rd_mux = sel_ctrl ? ctrl_word
                       : sel_stat ? stat_word
                       : sel_acc ? acc_word
                       : sel_ad ? (is_data_fn ? ext_rd : held_addr)
                       : sel_cap ? CAP_VALUE
                       : sel_np ? np_word
                       : 16'h0000;

  // Test mode is forced to normal outside gigabit copper operation
  wire [2:0] next_test_out = SPEED_GIG ? test_mode : GPR_TEST_NORMAL;

  // Control register; reserved test codes are stored as written
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      test_mode <= RST_TEST;
      forced_role_enable <= RST_FORCE_EN;
      forced_role_value <= RST_FORCE_VAL;
      port_type <= RST_PORT_TYPE;
      advertise_gig_full_duplex <= RST_ADV_FDX;
      advertise_gig_half_duplex <= RST_ADV_HDX;
    end
    else if (wr_ctrl)
    begin
      test_mode <= WDATA[CTRL_TEST_HI:CTRL_TEST_LO];
      forced_role_enable <= WDATA[CTRL_FORCE_EN_BIT];
      forced_role_value <= WDATA[CTRL_FORCE_VAL_BIT];
      port_type <= WDATA[CTRL_PORT_TYPE_BIT];
      advertise_gig_full_duplex <= WDATA[CTRL_ADV_FDX_BIT];
      advertise_gig_half_duplex <= WDATA[CTRL_ADV_HDX_BIT];
    end
  end

  // Configuration outputs to the core
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      TEST_MODE <= GPR_TEST_NORMAL;
      FORCE_ROLE_ENABLE <= RST_FORCE_EN;
      FORCE_ROLE_MASTER <= RST_FORCE_VAL;
      ADVERTISE_MULTI_PORT <= RST_PORT_TYPE;
      ADVERTISE_GIG_FDX <= RST_ADV_FDX;
      ADVERTISE_GIG_HDX <= RST_ADV_HDX;
    end
    else
    begin
      TEST_MODE <= next_test_out;
      FORCE_ROLE_ENABLE <= forced_role_enable;
      FORCE_ROLE_MASTER <= forced_role_enable && forced_role_value;
      ADVERTISE_MULTI_PORT <= port_type;
      ADVERTISE_GIG_FDX <= advertise_gig_full_duplex;
      ADVERTISE_GIG_HDX <= advertise_gig_half_duplex;
    end
  end

  // Status capture; software writes never reach these
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      role_fault <= 1'b0;
      role_resolved <= RST_RESOLVED;
      local_ok <= 1'b0;
      remote_ok <= 1'b0;
      partner_gig_full_duplex <= 1'b0;
      partner_gig_half_duplex <= 1'b0;
      idle_error_counter <= 8'h00;
    end
    else
    begin
      role_fault <= next_role_fault;
      role_resolved <= ROLE_IS_MASTER;
      local_ok <= LOCAL_RX_OK;
      remote_ok <= REMOTE_RX_OK;
      partner_gig_full_duplex <= PARTNER_GIG_FDX;
      partner_gig_half_duplex <= PARTNER_GIG_HDX;
      idle_error_counter <= next_idle_error_counter;
    end
  end

  // Indirect access registers
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      indirect_function <= GPR_FN_ADDR;
      indirect_device_select <= RST_DEV;
      held_addr <= RST_ADDR_DATA;
    end
    else
    begin
      if (wr_acc)
      begin
        indirect_function <= gpr_func_t'(WDATA[ACC_FUNC_HI:ACC_FUNC_LO]);
        indirect_device_select <= WDATA[ACC_DEV_HI:0];
      end
      held_addr <= next_held_addr;
    end
  end

  // Extended storage, cleared at reset so reads are never undefined
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      for (int i = 0; i < EXT_DEPTH; i++)
      begin
        ext_mem[i] <= 16'h0000;
      end
    end
    else if (data_wr && ext_hit)
    begin
      ext_mem[ext_slot] <= WDATA;
    end
  end

  // Read data and page toggle
  always_ff @(posedge CLK)
  begin
    if (RESET)
    begin
      RDATA <= 16'h0000;
      NEXT_PAGE_TOGGLE <= 1'b0;
    end
    else
    begin
      RDATA <= RD ? rd_mux : 16'h0000;
      if (PAGE_SENT)
      begin
        NEXT_PAGE_TOGGLE <= !NEXT_PAGE_TOGGLE;
      end
    end
  end

  // Checks
  a_test_mode_gate: assert property (@(posedge CLK) disable iff (RESET)
    !SPEED_GIG |=> TEST_MODE == GPR_TEST_NORMAL)
    else $error("Test mode left normal outside gigabit mode");

  a_test_mode_pass: assert property (@(posedge CLK) disable iff (RESET)
    (wr_ctrl && SPEED_GIG) ##1 SPEED_GIG |=> TEST_MODE
      == $past(WDATA[CTRL_TEST_HI:CTRL_TEST_LO], 2))
    else $error("Written test mode did not reach the transmitter");

  a_forced_role: assert property (@(posedge CLK) disable iff (RESET)
    FORCE_ROLE_MASTER |-> FORCE_ROLE_ENABLE)
    else $error("Forced master without forced role enable");

  a_fault_sticky: assert property (@(posedge CLK) disable iff (RESET)
    ROLE_FAULT_EVT ##1 (RD && ADDR == OFS_STAT) |=> RDATA[STAT_FAULT_BIT])
    else $error("Role fault lost before status read");

  a_fault_reported: assert property (@(posedge CLK) disable iff (RESET)
    (rd_stat && role_fault) |=> RDATA[STAT_FAULT_BIT])
    else $error("Set role fault not shown by status read");

  a_fault_set_wins: assert property (@(posedge CLK) disable iff (RESET)
    ROLE_FAULT_EVT |=> role_fault)
    else $error("Role fault event did not set the flag");

  a_fault_clear: assert property (@(posedge CLK) disable iff (RESET)
    (rd_stat && !ROLE_FAULT_EVT) |=> !role_fault)
    else $error("Role fault not cleared by status read");

  a_ro_ignored: assert property (@(posedge CLK) disable iff (RESET)
    (WR && sel_stat && !role_fault && !ROLE_FAULT_EVT) |=> !role_fault)
    else $error("Status write changed role fault");

  a_counter_step: assert property (@(posedge CLK) disable iff (RESET)
    (IDLE_ERR_EVT && !rd_stat) |=> idle_error_counter
      == ($past(idle_error_counter) == CNT_MAX ? CNT_MAX : $past(idle_error_counter) + 8'h01))
    else $error("Idle error counter stepped wrongly");

  a_counter_clear: assert property (@(posedge CLK) disable iff (RESET)
    (rd_stat && !IDLE_ERR_EVT) |=> idle_error_counter == 8'h00)
    else $error("Idle error counter not cleared on read");

  a_counter_evt_read: assert property (@(posedge CLK) disable iff (RESET)
    (rd_stat && IDLE_ERR_EVT) |=> idle_error_counter == 8'h01)
    else $error("Error on the clearing read was lost");

  a_rdata_idle: assert property (@(posedge CLK) disable iff (RESET)
    !RD |=> RDATA == 16'h0000)
    else $error("Read data not zero outside the read answer cycle");

  a_addr_write: assert property (@(posedge CLK) disable iff (RESET)
    (wr_ad && !is_data_fn) |=> held_addr == $past(WDATA))
    else $error("Address function write did not set held address");

  a_post_inc_wr: assert property (@(posedge CLK) disable iff (RESET)
    (data_wr && inc_on_wr) |=> held_addr == 16'($past(held_addr) + 16'h0001))
    else $error("Held address did not advance after data write");

  a_post_inc_rd: assert property (@(posedge CLK) disable iff (RESET)
    (data_rd && inc_on_rd) |=> held_addr == 16'($past(held_addr) + 16'h0001))
    else $error("Held address did not advance after data read");

  a_no_inc_read: assert property (@(posedge CLK) disable iff (RESET)
    (data_rd && indirect_function != GPR_FN_DATA_INC_RW) |=> $stable(held_addr))
    else $error("Held address moved on a read without read increment");

  a_cap_value: assert property (@(posedge CLK) disable iff (RESET)
    (RD && sel_cap) |=> RDATA == CAP_VALUE)
    else $error("Capability register read wrong value");

  a_page_toggle: assert property (@(posedge CLK) disable iff (RESET)
    PAGE_SENT |=> NEXT_PAGE_TOGGLE != $past(NEXT_PAGE_TOGGLE))
    else $error("Next-page toggle did not alternate");

endmodule : gpr_regs

// ### include/gpr_pkg.sv
// Constants for the gigabit control/status and indirect extended register bank.
// Assumes a 5-bit register index and 16-bit register data on the access port.
package gpr_pkg;

  // Register indices on the access port
  localparam logic [4:0] OFS_NP_TX = 5'h07;
  localparam logic [4:0] OFS_CTRL = 5'h09;
  localparam logic [4:0] OFS_STAT = 5'h0A;
  localparam logic [4:0] OFS_ACC = 5'h0D;
  localparam logic [4:0] OFS_ADDR_DATA = 5'h0E;
  localparam logic [4:0] OFS_CAP = 5'h0F;

  // Gigabit control fields
  localparam int CTRL_TEST_HI = 15;
  localparam int CTRL_TEST_LO = 13;
  localparam int CTRL_FORCE_EN_BIT = 12;
  localparam int CTRL_FORCE_VAL_BIT = 11;
  localparam int CTRL_PORT_TYPE_BIT = 10;
  localparam int CTRL_ADV_FDX_BIT = 9;
  localparam int CTRL_ADV_HDX_BIT = 8;
  localparam int CTRL_RSVD_HI = 7;

  // Gigabit status fields
  localparam int STAT_FAULT_BIT = 15;
  localparam int STAT_RESOLVED_BIT = 14;
  localparam int STAT_LOCAL_OK_BIT = 13;
  localparam int STAT_REMOTE_OK_BIT = 12;
  localparam int STAT_LP_FDX_BIT = 11;
  localparam int STAT_LP_HDX_BIT = 10;
  localparam int STAT_RSVD_HI = 9;
  localparam int STAT_RSVD_LO = 8;
  localparam int STAT_CNT_HI = 7;

  // Indirect access function register fields
  localparam int ACC_FUNC_HI = 15;
  localparam int ACC_FUNC_LO = 14;
  localparam int ACC_RSVD_HI = 13;
  localparam int ACC_RSVD_LO = 5;
  localparam int ACC_DEV_HI = 4;

  // Next-page transmit toggle position
  localparam int NP_TOGGLE_BIT = 11;

  // Reset values
  localparam logic [2:0] RST_TEST = 3'h0;
  localparam logic RST_FORCE_EN = 1'b0;
  localparam logic RST_FORCE_VAL = 1'b0;
  localparam logic RST_PORT_TYPE = 1'b1;
  localparam logic RST_ADV_FDX = 1'b1;
  localparam logic RST_ADV_HDX = 1'b1;
  localparam logic RST_RESOLVED = 1'b1;
  localparam logic [4:0] RST_DEV = 5'h00;
  localparam logic [15:0] RST_ADDR_DATA = 16'h0000;
  localparam logic [7:0] CNT_MAX = 8'hFF;

  // Fixed capability word: no fibre, copper gigabit full and half duplex
  localparam logic [15:0] CAP_VALUE = 16'h3000;

  // Extended devices backed by storage
  localparam logic [4:0] DEV_PCS = 5'h03;
  localparam logic [4:0] DEV_AN = 5'h07;

  typedef enum logic [1:0] {
    GPR_FN_ADDR = 2'b00,
    GPR_FN_DATA = 2'b01,
    GPR_FN_DATA_INC_RW = 2'b10,
    GPR_FN_DATA_INC_W = 2'b11
  } gpr_func_t;

  typedef enum logic [2:0] {
    GPR_TEST_NORMAL = 3'b000,
    GPR_TEST_WAVEFORM = 3'b001,
    GPR_TEST_JITTER_MASTER = 3'b010,
    GPR_TEST_JITTER_SLAVE = 3'b011,
    GPR_TEST_DISTORTION = 3'b100
  } gpr_test_t;

endpackage : gpr_pkg

// ### tb/gpr_partner.sv
// Link partner model: drives the receiver, role and ability levels and the event pulses.
// Assumes the bank's clock; the bench calls the tasks to stage each situation.
`timescale 1ns/1ns
module gpr_partner
  import gpr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Levels and events toward the bank
  output logic fault_evt,
  output logic is_master,
  output logic local_ok,
  output logic remote_ok,
  output logic lp_fdx,
  output logic lp_hdx,
  output logic err_evt
);

  // Settled link: we are master, nothing trained yet
  initial
  begin
    fault_evt = 1'b0;
    is_master = 1'b1;
    local_ok = 1'b0;
    remote_ok = 1'b0;
    lp_fdx = 1'b0;
    lp_hdx = 1'b0;
    err_evt = 1'b0;
  end

  task automatic set_link(input logic m, input logic lo, input logic ro, input logic f,
                          input logic h);
    @(posedge clk);
    is_master <= m;
    local_ok <= lo;
    remote_ok <= ro;
    lp_fdx <= f;
    lp_hdx <= h;
  endtask : set_link

  task automatic send_fault();
    @(posedge clk);
    fault_evt <= 1'b1;
    @(posedge clk);
    fault_evt <= 1'b0;
  endtask : send_fault

  // Back-to-back errors, one per cycle, the worst case for the counter
  task automatic send_errors(input int n);
    repeat (n)
    begin
      @(posedge clk);
      err_evt <= 1'b1;
    end
    @(posedge clk);
    err_evt <= 1'b0;
  endtask : send_errors

endmodule : gpr_partner

// ### tb/gpr_regs_bench.sv
// Self-checking bench for the gigabit register bank and indirect extended window.
// Assumes the partner model drives the core status inputs; the bench is the software.
`timescale 1ns/1ns
module gpr_regs_bench
  import gpr_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic speed_gig = 1'b1;
  logic page_sent = 1'b0;
  logic [15:0] rdata;
  logic [2:0] test_mode;
  logic force_en, force_master, adv_multi, adv_fdx, adv_hdx, np_toggle;
  logic fault_evt, is_master, local_ok, remote_ok, lp_fdx, lp_hdx, err_evt;
  int fails = 0;
  int total_checks = 0;

  always #4 clk = ~clk;

  gpr_regs i_dut (.CLK(clk), .RESET(reset), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .SPEED_GIG(speed_gig), .ROLE_FAULT_EVT(fault_evt),
    .ROLE_IS_MASTER(is_master), .LOCAL_RX_OK(local_ok), .REMOTE_RX_OK(remote_ok),
    .PARTNER_GIG_FDX(lp_fdx), .PARTNER_GIG_HDX(lp_hdx), .IDLE_ERR_EVT(err_evt),
    .PAGE_SENT(page_sent), .TEST_MODE(test_mode), .FORCE_ROLE_ENABLE(force_en),
    .FORCE_ROLE_MASTER(force_master), .ADVERTISE_MULTI_PORT(adv_multi),
    .ADVERTISE_GIG_FDX(adv_fdx), .ADVERTISE_GIG_HDX(adv_hdx), .NEXT_PAGE_TOGGLE(np_toggle));

  gpr_partner i_partner (.clk(clk), .fault_evt(fault_evt), .is_master(is_master),
    .local_ok(local_ok), .remote_ok(remote_ok), .lp_fdx(lp_fdx), .lp_hdx(lp_hdx),
    .err_evt(err_evt));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask : rd_chk

  // Control pins land one cycle after the register
  task automatic ctl(input logic [15:0] d, input logic [4:0] exp);
    wr_reg(OFS_CTRL, d);
    @(posedge clk);
    #1 check({11'h000, force_en, force_master, adv_multi, adv_fdx, adv_hdx}, {11'h000, exp});
  endtask : ctl

  task automatic t_reset();
    rd_chk(OFS_CTRL, 16'h0700);
    rd_chk(OFS_STAT, 16'h4000);
    rd_chk(OFS_CAP, 16'h3000);
    wr_reg(OFS_CAP, 16'h0000);
    rd_chk(OFS_CAP, 16'h3000);
    rd_chk(5'h1F, 16'h0000);
    $display("reset values done");
  endtask : t_reset

  task automatic t_ctrl();
    for (int i = 0; i < 5; i++)
    begin
      wr_reg(OFS_CTRL, {i[2:0], 13'h0700});
      @(posedge clk);
      #1 check({13'h0000, test_mode}, 16'(i));
    end
    @(posedge clk);
    speed_gig <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check({13'h0000, test_mode}, 16'h0000);
    ctl(16'h1800, 5'b11000);
    ctl(16'h1000, 5'b10000);
    ctl(16'h0800, 5'b00000);
    ctl(16'h0500, 5'b00101);
    rd_chk(OFS_CTRL, 16'h0500);
    @(posedge clk);
    speed_gig <= 1'b1;
    $display("control done");
  endtask : t_ctrl

  task automatic t_status();
    i_partner.set_link(1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    // Status read right behind the fault pulse
    fork
      i_partner.send_fault();
      begin
        @(posedge clk);
        rd_chk(OFS_STAT, 16'hB800);
      end
    join
    rd_chk(OFS_STAT, 16'h3800);
    i_partner.set_link(1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    i_partner.send_errors(3);
    repeat (2) @(posedge clk);
    wr_reg(OFS_STAT, 16'h0000);
    rd_chk(OFS_STAT, 16'h4403);
    rd_chk(OFS_STAT, 16'h4400);
    i_partner.send_errors(300);
    repeat (2) @(posedge clk);
    rd_chk(OFS_STAT, 16'h44FF);
    // Event and clear-on-read in one cycle: the event wins
    fork
      rd_chk(OFS_STAT, 16'h4400);
      i_partner.send_fault();
      i_partner.send_errors(1);
    join
    rd_chk(OFS_STAT, 16'hC401);
    $display("status done");
  endtask : t_status

  task automatic t_indirect();
    wr_reg(OFS_ACC, 16'h0003);
    wr_reg(OFS_ADDR_DATA, 16'h0002);
    wr_reg(OFS_ACC, 16'h8003);
    wr_reg(OFS_ADDR_DATA, 16'h1111);
    wr_reg(OFS_ADDR_DATA, 16'h2222);
    wr_reg(OFS_ACC, 16'h0003);
    rd_chk(OFS_ADDR_DATA, 16'h0004);
    rd_chk(OFS_ACC, 16'h0003);
    wr_reg(OFS_ADDR_DATA, 16'h0002);
    wr_reg(OFS_ACC, 16'h4003);
    rd_chk(OFS_ADDR_DATA, 16'h1111);
    rd_chk(OFS_ADDR_DATA, 16'h1111);
    wr_reg(OFS_ACC, 16'hC003);
    rd_chk(OFS_ADDR_DATA, 16'h1111);
    wr_reg(OFS_ADDR_DATA, 16'h3333);
    rd_chk(OFS_ADDR_DATA, 16'h2222);
    wr_reg(OFS_ACC, 16'h8003);
    rd_chk(OFS_ADDR_DATA, 16'h2222);
    rd_chk(OFS_ADDR_DATA, 16'h0000);
    wr_reg(OFS_ACC, 16'h0007);
    wr_reg(OFS_ADDR_DATA, 16'h0002);
    wr_reg(OFS_ACC, 16'h4007);
    rd_chk(OFS_ADDR_DATA, 16'h0000);
    wr_reg(OFS_ACC, 16'h4003);
    rd_chk(OFS_ADDR_DATA, 16'h3333);
    $display("indirect done");
  endtask : t_indirect

  task automatic t_page();
    for (int i = 1; i < 3; i++)
    begin
      @(posedge clk);
      page_sent <= 1'b1;
      @(posedge clk);
      page_sent <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check({15'h0000, np_toggle}, 16'(i % 2));
      rd_chk(OFS_NP_TX, (i % 2) ? 16'h0800 : 16'h0000);
    end
    $display("next page done");
  endtask : t_page

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // Whole run is under five hundred cycles; this is ample margin
  initial
  begin
    #200000;
    fails++;
    end_of_test();
  end

  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_ctrl();
    t_status();
    t_indirect();
    t_page();
    end_of_test();
  end

endmodule : gpr_regs_bench
